// ### shared/csm_pkg.sv
// Package with constants, frame layout and register map of the channel switch matrix.
`default_nettype none
package csm_pkg;
  localparam int unsigned NUM_CHANNELS = 6;
  localparam int unsigned FRAME_BITS   = 8;
  localparam int unsigned SYNC_STAGES  = 2;

  // Frame field positions, first bit sent is bit 7.
  localparam int unsigned FRM_DIR_POS  = 7;
  localparam int unsigned FRM_BANK_POS = 6;

  // Register bank and address codes.
  localparam logic       BANK_OUT       = 1'b0;
  localparam logic       BANK_CFG       = 1'b1;
  localparam logic [1:0] ADDR_HW_CONFIG = 2'b10;
  localparam logic [1:0] ADDR_SENSE_MUX = 2'b01;

  // Hardware configuration data bit positions.
  localparam int unsigned HWC_CTL_POS  = 0;
  localparam int unsigned HWC_RST_POS  = 1;
  localparam int unsigned HWC_STB_POS  = 1;
  localparam int unsigned HWC_GATE_POS = 3;

  // Values after reset.
  localparam logic [5:0] OUT_RESET       = 6'h00;
  localparam logic       GATE_RESET      = 1'b0;
  localparam logic       CTL_RESET       = 1'b0;
  localparam logic [2:0] SENSE_MUX_RESET = 3'h7;
  localparam logic [2:0] SENSE_MUX_STBY  = 3'h7;
  localparam logic       TER_RESET       = 1'b1;

  // Gating modes.
  localparam logic GATE_OR  = 1'b0;
  localparam logic GATE_AND = 1'b1;

  typedef enum logic [2:0] {
    SEL_OUT = 3'b001,
    SEL_HWC = 3'b010,
    SEL_MUX = 3'b100
  } csm_sel_t;

  typedef struct packed {
    logic       write;
    logic       bank;
    logic [1:0] addr;
    logic [3:0] data;
  } csm_cmd_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } csm_spi_in_t;
endpackage
`default_nettype wire

// ### rtl/csm_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module csm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // Only the second stage is visible outside.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/csm_top.sv
// Serially programmed six channel switch matrix with hardware configuration register.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Six independent channel on/off paths.
// R2: Channel driven by input pin and register bit.
// R3: Gating mode 0: register bit OR pin.
// R4: Gating mode 1: register bit AND pin.
// R5: Open input pin reads as low.
// R6: Reset command bit write-only; 1 resets.
// R7: Stand-by bit read-only, 1 in stand-by.
// R8: Frame: direction, bank, address, four data.
// R9: Reset command equals power-on reset, outputs kept; the code clears out_q, so channels then follow the pins.
// R10: First frame after reset returns output, error set.
// R11: Stand-by while sense mux select is 111.
// R12: One gating bit applies to all channels.
module csm_top
  import csm_pkg::*;
(
  input  wire logic                             CORE_CLK_I,
  input  wire logic                             RST_I,
  input  wire logic                             SCLK_I,
  input  wire logic                             CS_N_I,
  input  wire logic                             SI_I,
  output var  logic                             SO_O,
  output var  logic                             SO_OE_O,
  input  wire logic [csm_pkg::NUM_CHANNELS-1:0] CHANNEL_INPUT_PIN_I,
  output var  logic [csm_pkg::NUM_CHANNELS-1:0] CHANNEL_OUTPUT_O,
  output var  logic                             STANDBY_INDICATION_O
);
  import csm_pkg::*;

  csm_spi_in_t               spi_s;
  logic [2:0]                spi_raw;
  logic [NUM_CHANNELS-1:0]   pin_s;

  // Pins are asynchronous to the core clock, so every one passes two flops.
  // Chip select passes inverted, so a cleared synchroniser reads as deselected.
  // Otherwise every reset would be followed by a false frame and a reply enable pulse.
  csm_sync #(.WIDTH(3)) u_spi_sync (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .async_i ({SCLK_I, ~CS_N_I, SI_I}),
    .sync_o  (spi_raw)
  );

  assign spi_s = csm_spi_in_t'({spi_raw[2], ~spi_raw[1], spi_raw[0]});

  // An open pin is pulled low outside, and the synchroniser resets to low, so it never switches a channel on.
  csm_sync #(.WIDTH(NUM_CHANNELS)) u_pin_sync ( // R5
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .async_i (CHANNEL_INPUT_PIN_I),
    .sync_o  (pin_s)
  );

  // Serial shifter state.
  logic                    sclk_q, sclk_d;
  logic                    cs_n_q, cs_n_d;
  logic [3:0]              cnt_q, cnt_d;
  logic [FRAME_BITS-1:0]   rx_q, rx_d;
  logic [FRAME_BITS-1:0]   tx_q, tx_d;
  logic                    so_q, so_d;
  logic                    so_oe_q, so_oe_d;

  // Register file state.
  logic [NUM_CHANNELS-1:0] out_q, out_d;
  logic                    gate_q, gate_d;
  logic                    ctl_q, ctl_d;
  logic [2:0]              mux_q, mux_d;
  logic                    ter_q, ter_d;
  csm_sel_t                sel_q, sel_d;
  logic                    stby_q, stby_d;

  // Channel state.
  logic [NUM_CHANNELS-1:0] ch_q, ch_d;

  logic                    sclk_rise;
  logic                    sclk_fall;
  logic                    cs_start;
  logic                    cs_end;
  logic                    frame_ok;
  csm_cmd_t                cmd;
  logic                    soft_rst;
  logic [FRAME_BITS-1:0]   reply;

  assign sclk_rise = spi_s.sclk & ~sclk_q & ~spi_s.cs_n;
  assign sclk_fall = ~spi_s.sclk & sclk_q & ~spi_s.cs_n;
  assign cs_start  = cs_n_q & ~spi_s.cs_n;
  assign cs_end    = ~cs_n_q & spi_s.cs_n;
  assign frame_ok  = cs_end && (cnt_q == 4'(FRAME_BITS));
  assign cmd       = csm_cmd_t'(rx_q); // R8
  assign soft_rst  = frame_ok && cmd.write && cmd.bank == BANK_CFG && cmd.addr == ADDR_HW_CONFIG
                     && cmd.data[HWC_RST_POS]; // R6 R9

  // The reply carries the error bit on top, then the selected register.
  always_comb begin
    reply = '0;
    unique case (sel_q)
      SEL_HWC: reply = {ter_q, BANK_CFG, ADDR_HW_CONFIG, gate_q, 1'b0, stby_q, ctl_q}; // R7
      SEL_MUX: reply = {ter_q, BANK_CFG, ADDR_SENSE_MUX, 1'b0, mux_q};
      SEL_OUT: reply = {ter_q, 1'b0, out_q}; // R10
    endcase
  end

  // Shifter: sample on rising edge, present next bit on falling edge, mode 0.
  always_comb begin
    sclk_d  = spi_s.sclk;
    cs_n_d  = spi_s.cs_n;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    so_d    = so_q;
    so_oe_d = ~spi_s.cs_n;
    if (cs_start) begin
      cnt_d = 4'h0;
      tx_d  = {reply[FRAME_BITS-2:0], 1'b0};
      so_d  = reply[FRAME_BITS-1];
    end else if (sclk_rise) begin
      rx_d = {rx_q[FRAME_BITS-2:0], spi_s.si};
      if (cnt_q != 4'hf) begin
        cnt_d = cnt_q + 4'h1;
      end
    end else if (sclk_fall) begin
      so_d = tx_q[FRAME_BITS-1];
      tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      cnt_q   <= 4'h0;
      rx_q    <= '0;
      tx_q    <= '0;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      sclk_q  <= sclk_d;
      cs_n_q  <= cs_n_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      so_q    <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  // Register file; a finished frame is decoded once, at chip select release.
  always_comb begin
    out_d  = out_q;
    gate_d = gate_q;
    ctl_d  = ctl_q;
    mux_d  = mux_q;
    ter_d  = ter_q;
    sel_d  = sel_q;
    if (soft_rst) begin // R9
      out_d  = OUT_RESET;
      gate_d = GATE_RESET;
      ctl_d  = CTL_RESET;
      mux_d  = SENSE_MUX_RESET;
      ter_d  = TER_RESET; // R10
      sel_d  = SEL_OUT; // R10
    end else if (cs_end) begin
      // A short or long frame is flagged and otherwise ignored; the flag setting wins over its clear.
      ter_d = ~frame_ok;
      if (frame_ok) begin
        if (cmd.write) begin // R8
          sel_d = SEL_OUT;
          if (cmd.bank == BANK_OUT) begin
            out_d = rx_q[NUM_CHANNELS-1:0]; // R2
          end else if (cmd.addr == ADDR_HW_CONFIG) begin
            gate_d = cmd.data[HWC_GATE_POS]; // R12
            ctl_d  = cmd.data[HWC_CTL_POS];
          end else if (cmd.addr == ADDR_SENSE_MUX) begin
            mux_d = cmd.data[2:0]; // R11
          end
        end else if (cmd.bank == BANK_CFG && cmd.addr == ADDR_HW_CONFIG) begin
          sel_d = SEL_HWC;
        end else if (cmd.bank == BANK_CFG && cmd.addr == ADDR_SENSE_MUX) begin
          sel_d = SEL_MUX;
        end else begin
          sel_d = SEL_OUT;
        end
      end
    end
  end

  // Stand-by follows the mux select; it is derived, so software cannot write it.
  always_comb begin
    stby_d = (mux_q == SENSE_MUX_STBY); // R7 R11
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      out_q  <= OUT_RESET;
      gate_q <= GATE_RESET;
      ctl_q  <= CTL_RESET;
      mux_q  <= SENSE_MUX_RESET;
      ter_q  <= TER_RESET;
      sel_q  <= SEL_OUT;
      stby_q <= 1'b1;
    end else begin
      out_q  <= out_d;
      gate_q <= gate_d;
      ctl_q  <= ctl_d;
      mux_q  <= mux_d;
      ter_q  <= ter_d;
      sel_q  <= sel_d;
      stby_q <= stby_d;
    end
  end

  // Switch matrix, one path per channel.
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch // R1
    always_comb begin
      if (gate_q == GATE_AND) begin
        ch_d[i] = out_q[i] & pin_s[i]; // R4
      end else begin
        ch_d[i] = out_q[i] | pin_s[i]; // R3
      end
    end
  end

  // The reset command clears registers only; this flop takes no soft reset.
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ch_q <= '0;
    end else begin
      ch_q <= ch_d;
    end
  end

  assign SO_O                 = so_q;
  assign SO_OE_O              = so_oe_q;
  assign CHANNEL_OUTPUT_O     = ch_q;
  assign STANDBY_INDICATION_O = stby_q;
endmodule
`default_nettype wire

// ### tb/csm_host.sv
// Host serial master model that frames commands and collects replies.
`timescale 1ns/1ps
`default_nettype none
module csm_host (
  input  wire logic clk_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic si_o,
  input  wire logic so_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // Eight bits make a frame; a shorter count sends a frame that the block must refuse.
  task automatic xfer_n(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    for (int i = 7; i >= 8 - nbits; i--) begin
      si_o <= tx[i];
      repeat (5) @(posedge clk_i);
      rx[i] = so_i;
      sclk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // A deselected data line must not keep its last level.
    si_o <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    xfer_n(tx, 8, rx);
  endtask
endmodule
`default_nettype wire

// ### tb/csm_top_checker.sv
// Port level assertions for the switch matrix top.
`timescale 1ns/1ps
`default_nettype none
module csm_top_checker
  import csm_pkg::*;
(
  input wire logic                             CORE_CLK_I,
  input wire logic                             RST_I,
  input wire logic                             SCLK_I,
  input wire logic                             CS_N_I,
  input wire logic                             SI_I,
  input wire logic                             SO_O,
  input wire logic                             SO_OE_O,
  input wire logic [csm_pkg::NUM_CHANNELS-1:0] CHANNEL_INPUT_PIN_I,
  input wire logic [csm_pkg::NUM_CHANNELS-1:0] CHANNEL_OUTPUT_O,
  input wire logic                             STANDBY_INDICATION_O
);
  logic [3:0]              pin_cnt_q, pin_cnt_d, cs_cnt_q, cs_cnt_d;
  logic [NUM_CHANNELS-1:0] pin_prev_q;
  logic                    cs_prev_q;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Cycles since the last cause that may move an output.
  always_comb begin
    pin_cnt_d = (pin_cnt_q == 4'hf) ? pin_cnt_q : pin_cnt_q + 4'h1;
    cs_cnt_d  = (cs_cnt_q == 4'hf) ? cs_cnt_q : cs_cnt_q + 4'h1;
    if (CS_N_I && !cs_prev_q) cs_cnt_d = 4'h0;
    if (CS_N_I && !cs_prev_q || CHANNEL_INPUT_PIN_I != pin_prev_q) pin_cnt_d = 4'h0;
    if (RST_I) pin_cnt_d = 4'h0;
    if (RST_I) cs_cnt_d = 4'hf;
  end
  always_ff @(posedge CORE_CLK_I) begin
    pin_cnt_q  <= pin_cnt_d;
    cs_cnt_q   <= cs_cnt_d;
    pin_prev_q <= CHANNEL_INPUT_PIN_I;
    cs_prev_q  <= CS_N_I;
  end
  property p_rst_outs;
    disable iff (1'b0) RST_I |=> CHANNEL_OUTPUT_O == '0 && STANDBY_INDICATION_O && !SO_OE_O;
  endproperty
  property p_stby_hold; $fell(RST_I) |-> STANDBY_INDICATION_O [*3]; endproperty
  property p_stby_cause; $changed(STANDBY_INDICATION_O) |-> cs_cnt_q inside {[2:9]}; endproperty
  property p_out_cause; $changed(CHANNEL_OUTPUT_O) |-> pin_cnt_q <= 4'h8; endproperty
  property p_oe_on; $fell(CS_N_I) |-> ##[1:5] SO_OE_O; endproperty
  property p_oe_off; $rose(CS_N_I) |-> ##[1:6] !SO_OE_O; endproperty
  property p_oe_idle; CS_N_I [*6] |-> !SO_OE_O; endproperty
  property p_so_shift; $changed(SO_O) && SO_OE_O && $past(SO_OE_O) |-> !SCLK_I; endproperty
  a_rst_outs: assert property (p_rst_outs) else $error("reset outputs wrong");
  a_stby_hold: assert property (p_stby_hold) else $error("standby lost after reset");
  a_stby_cause: assert property (p_stby_cause) else $error("standby moved without frame");
  a_out_cause: assert property (p_out_cause) else $error("output moved without cause");
  a_oe_on: assert property (p_oe_on) else $error("reply not enabled");
  a_oe_off: assert property (p_oe_off) else $error("reply not released");
  a_oe_idle: assert property (p_oe_idle) else $error("reply driven while idle");
  a_so_shift: assert property (p_so_shift) else $error("reply moved with clock high");
  c_wake: cover property ($fell(STANDBY_INDICATION_O));
  c_out: cover property ($changed(CHANNEL_OUTPUT_O));
  c_frame: cover property ($fell(CS_N_I));
endmodule
bind csm_top csm_top_checker csm_top_checker_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
  .SCLK_I(SCLK_I), .CS_N_I(CS_N_I), .SI_I(SI_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O),
  .CHANNEL_INPUT_PIN_I(CHANNEL_INPUT_PIN_I), .CHANNEL_OUTPUT_O(CHANNEL_OUTPUT_O),
  .STANDBY_INDICATION_O(STANDBY_INDICATION_O));
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the channel switch matrix.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csm_pkg::*;
  logic                    clk, rst, sclk, cs_n, si, so, so_oe, stby;
  logic [NUM_CHANNELS-1:0] pins, chan;
  logic [7:0]              rx;
  int                      err_count, tests_run, cycles;
  csm_top csm_top_inst (.CORE_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
    .SO_O(so), .SO_OE_O(so_oe), .CHANNEL_INPUT_PIN_I(pins), .CHANNEL_OUTPUT_O(chan),
    .STANDBY_INDICATION_O(stby));
  csm_host csm_host_inst (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
    csm_host_inst.xfer(tx, rx);
    chk(rx, exp);
  endtask
  task automatic outs(input logic [5:0] ch, input logic sb);
    chk({2'h0, chan}, {2'h0, ch});
    chk({7'h0, stby}, {7'h0, sb});
  endtask
  task automatic set_pins(input logic [5:0] v);
    @(posedge clk);
    pins <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The whole sequence needs under 2000 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    pins = '0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    outs(6'h00, 1'b1);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    frame(8'h95, 8'h80);
    outs(6'h15, 1'b1);
    $display("Test reset and first frame done");
    set_pins(6'h2a);
    outs(6'h3f, 1'b1);
    $display("Test or gating done");
    frame(8'he9, 8'h15);
    outs(6'h00, 1'b1);
    set_pins(6'h3f);
    outs(6'h15, 1'b1);
    $display("Test and gating done");
    frame(8'h60, 8'h15);
    frame(8'h00, 8'h6b);
    $display("Test configuration read done");
    frame(8'hd6, 8'h15);
    outs(6'h15, 1'b0);
    frame(8'h60, 8'h15);
    frame(8'h00, 8'h69);
    $display("Test wake done");
    set_pins(6'h0c);
    frame(8'he2, 8'h15);
    outs(6'h0c, 1'b1);
    frame(8'h00, 8'h80);
    set_pins(6'h00);
    outs(6'h00, 1'b1);
    $display("Test reset command done");
    csm_host_inst.xfer_n(8'hbf, 7, rx);
    chk(rx, 8'h00);
    frame(8'h00, 8'h80);
    outs(6'h00, 1'b1);
    $display("Test short frame done");
    frame(8'h8a, 8'h00);
    frame(8'hd5, 8'h0a);
    outs(6'h0a, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    outs(6'h00, 1'b1);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    frame(8'h00, 8'h80);
    $display("Test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
